// ---- src/tcpm_timer_pair.sv ----
// timer/counter pair with mode control, plus a plain third counter
// assumes an 8-bit sfr bus on the cpu clock and asynchronous pins
// How it works
// - each timer steps on a divided cpu clock or on its event pin
// - each count is 16 bits, read and written as low and high bytes
// - event pins: timer 0 port0 bit5, timer 1 bit6, timer 2 port1 bit0
// - timer 1 gate set: counts only with its irq pin high and run set
// - timer 0 gate set: counts only with its irq pin high and run set, except its split high byte, which ignores gate and pin
// - timer 1 source 0: cpu clock /4 or /12 by prescale bit; 1: pin
// - timer 0 source 0: cpu clock /4 or /12 by prescale bit; 1: pin
// - timer 1 mode: 13 bit, 16 bit, 8 bit reload, hold
// - timer 0 mode: 13 bit, 16 bit, 8 bit reload, two 8 bit
// - split mode only on timer 0; timer 1 holds in that mode
// - 13 bit mode wraps after all ones, sets flag, pulses output
// - reload mode copies the high byte into the low byte on wrap
// - a run bit enables its timer; cleared, the timer holds, except timer 0's split high byte, which runs on timer 1's run bit
// - overflow flag set on overflow, cleared when cpu vectors
`timescale 1ns/1ps
module tcpm_timer_pair (
  input wire logic sys_clk,
  input wire logic rst_n,
  input tcpm_pkg::tcpm_sfr_req_t sfrReq,
  output logic [7:0] sfrRdData,
  input wire logic [7:0] port0In,
  input wire logic [3:0] port1In,
  input wire logic extIrqPinA_n,
  input wire logic extIrqPinB_n,
  input wire logic vectorAckA,
  input wire logic vectorAckB,
  input wire logic timer2Run,
  input wire logic timer2EventSel,
  output logic overflowFlagA,
  output logic overflowFlagB,
  output logic tOutA,
  output logic tOutB
);

  // ----------------------------------------------------------------
  // step function for modes 0..2
  // ----------------------------------------------------------------
  function automatic tcpm_pkg::tcpm_step_t tcpm_step(
    input tcpm_pkg::tcpm_mode_t mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [12:0] c13;
    logic [15:0] c16;
    tcpm_pkg::tcpm_step_t r;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    r.ovf = 1'b0;
    r.hi = hi;
    r.lo = lo;
    case (mode)
      tcpm_pkg::MODE_13: begin
        // top three low bits are left alone, software masks them
        r.hi = c13[12:5];
        r.lo = {lo[7:5], c13[4:0]};
        r.ovf = &{hi, lo[4:0]};
      end
      tcpm_pkg::MODE_16: begin
        {r.hi, r.lo} = c16;
        r.ovf = &{hi, lo};
      end
      tcpm_pkg::MODE_RELOAD: begin
        r.lo = (&lo) ? hi : lo + 8'h01;
        r.ovf = &lo;
      end
      default: begin
        r.ovf = 1'b0;
      end
    endcase
    return r;
  endfunction : tcpm_step

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] modeSel_r;
  logic [7:0] runFlags_r;
  logic [7:0] runFlags_nxt;
  logic [7:0] clkDivCfg_r;
  logic [7:0] cntLoA_r;
  logic [7:0] cntHiA_r;
  logic [7:0] cntLoB_r;
  logic [7:0] cntHiB_r;
  logic [15:0] cntC_r;
  logic [7:0] cntLoA_nxt;
  logic [7:0] cntHiA_nxt;
  logic [7:0] cntLoB_nxt;
  logic [7:0] cntHiB_nxt;
  logic [15:0] cntC_nxt;
  logic [7:0] rdData_r;
  logic tOutA_r;
  logic tOutB_r;

  // ----------------------------------------------------------------
  // pins and ticks
  // ----------------------------------------------------------------
  logic [4:0] pinLevel;
  logic [4:0] pinFall;
  logic tickFast;
  logic tickSlow;

  tcpm_sync_edge #(
    .W(5)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pinIn({port1In[tcpm_pkg::EVT_C_PORT1_BIT],
            port0In[tcpm_pkg::EVT_B_PORT0_BIT],
            port0In[tcpm_pkg::EVT_A_PORT0_BIT],
            extIrqPinB_n, extIrqPinA_n}),
    .level(pinLevel),
    .fall(pinFall)
  );

  tcpm_prescale #(
    .SLOW(tcpm_pkg::DIV_SLOW),
    .FAST(tcpm_pkg::DIV_FAST)
  ) u_prescale (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tickFast(tickFast),
    .tickSlow(tickSlow)
  );

  wire extHighA = pinLevel[0];
  wire extHighB = pinLevel[1];
  wire evtFallA = pinFall[2];
  wire evtFallB = pinFall[3];
  wire evtFallC = pinFall[4];

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire wrRun = sfrReq.wr && sfrReq.addr == tcpm_pkg::ADDR_RUN_FLAGS;
  wire wrMode = sfrReq.wr && sfrReq.addr == tcpm_pkg::ADDR_MODE_SEL;
  wire wrDiv = sfrReq.wr && sfrReq.addr == tcpm_pkg::ADDR_CLK_DIV_CFG;
  wire wrLoA = sfrReq.wr && sfrReq.addr == tcpm_pkg::ADDR_CNT_LO_A;
  wire wrHiA = sfrReq.wr && sfrReq.addr == tcpm_pkg::ADDR_CNT_HI_A;
  wire wrLoB = sfrReq.wr && sfrReq.addr == tcpm_pkg::ADDR_CNT_LO_B;
  wire wrHiB = sfrReq.wr && sfrReq.addr == tcpm_pkg::ADDR_CNT_HI_B;
  wire wrLoC = sfrReq.wr && sfrReq.addr == tcpm_pkg::ADDR_CNT_LO_C;
  wire wrHiC = sfrReq.wr && sfrReq.addr == tcpm_pkg::ADDR_CNT_HI_C;

  // ----------------------------------------------------------------
  // timer 0
  // ----------------------------------------------------------------
  tcpm_pkg::tcpm_mode_half_t halfA;
  tcpm_pkg::tcpm_mode_half_t halfB;
  tcpm_pkg::tcpm_step_t stepA;
  tcpm_pkg::tcpm_step_t stepB;
  assign halfA = tcpm_pkg::tcpm_mode_half_t'(modeSel_r[3:0]);
  assign halfB = tcpm_pkg::tcpm_mode_half_t'(modeSel_r[7:4]);

  wire runA = runFlags_r[tcpm_pkg::RUN_A_BIT];
  wire runB = runFlags_r[tcpm_pkg::RUN_B_BIT];
  wire preA = clkDivCfg_r[tcpm_pkg::PRESCALE_A_BIT] ? tickFast : tickSlow;
  wire preB = clkDivCfg_r[tcpm_pkg::PRESCALE_B_BIT] ? tickFast : tickSlow;
  wire srcA = halfA.evtSel ? evtFallA : preA;
  wire enA = runA && (!halfA.gate || extHighA);
  wire incA = srcA && enA;
  wire splitA = halfA.mode == tcpm_pkg::MODE_SPLIT;
  // in split mode the high byte borrows timer 1's run bit and flag
  wire incHiSplit = splitA && preA && runB;
  wire ovfHiSplit = incHiSplit && (&cntHiA_r);
  assign stepA = tcpm_step(halfA.mode, cntLoA_r, cntHiA_r);
  wire ovfA = incA && (splitA ? (&cntLoA_r) : stepA.ovf);

  assign cntLoA_nxt = wrLoA ? sfrReq.wrData :
                      !incA ? cntLoA_r :
                      splitA ? cntLoA_r + 8'h01 : stepA.lo;
  assign cntHiA_nxt = wrHiA ? sfrReq.wrData :
                      splitA ? (incHiSplit ? cntHiA_r + 8'h01 : cntHiA_r) :
                      incA ? stepA.hi : cntHiA_r;

  // ----------------------------------------------------------------
  // timer 1
  // ----------------------------------------------------------------
  wire srcB = halfB.evtSel ? evtFallB : preB;
  wire enB = runB && (!halfB.gate || extHighB);
  // mode 3 on timer 1 simply stops it
  wire incB = srcB && enB && halfB.mode != tcpm_pkg::MODE_SPLIT;
  assign stepB = tcpm_step(halfB.mode, cntLoB_r, cntHiB_r);
  wire ovfB = incB && stepB.ovf;
  wire setFlagB = splitA ? ovfHiSplit : ovfB;

  assign cntLoB_nxt = wrLoB ? sfrReq.wrData : incB ? stepB.lo : cntLoB_r;
  assign cntHiB_nxt = wrHiB ? sfrReq.wrData : incB ? stepB.hi : cntHiB_r;

  // ----------------------------------------------------------------
  // timer 2, plain wrapping 16-bit count
  // ----------------------------------------------------------------
  wire incC = timer2Run && (timer2EventSel ? evtFallC : tickSlow);
  assign cntC_nxt = wrLoC ? {cntC_r[15:8], sfrReq.wrData} :
                    wrHiC ? {sfrReq.wrData, cntC_r[7:0]} :
                    incC ? cntC_r + 16'h0001 : cntC_r;

  // ----------------------------------------------------------------
  // flags: overflow beats both vector clear and software write
  // ----------------------------------------------------------------
  always_comb begin
    runFlags_nxt = wrRun ? sfrReq.wrData : runFlags_r;
    if (vectorAckA) begin
      runFlags_nxt[tcpm_pkg::FLAG_A_BIT] = 1'b0;
    end
    if (vectorAckB) begin
      runFlags_nxt[tcpm_pkg::FLAG_B_BIT] = 1'b0;
    end
    if (ovfA) begin
      runFlags_nxt[tcpm_pkg::FLAG_A_BIT] = 1'b1;
    end
    if (setFlagB) begin
      runFlags_nxt[tcpm_pkg::FLAG_B_BIT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read mux, unmapped reads give zero
  // ----------------------------------------------------------------
  wire [7:0] rdMux =
    sfrReq.addr == tcpm_pkg::ADDR_RUN_FLAGS ? runFlags_r :
    sfrReq.addr == tcpm_pkg::ADDR_MODE_SEL ? modeSel_r :
    sfrReq.addr == tcpm_pkg::ADDR_CLK_DIV_CFG ? clkDivCfg_r :
    sfrReq.addr == tcpm_pkg::ADDR_CNT_LO_A ? cntLoA_r :
    sfrReq.addr == tcpm_pkg::ADDR_CNT_HI_A ? cntHiA_r :
    sfrReq.addr == tcpm_pkg::ADDR_CNT_LO_B ? cntLoB_r :
    sfrReq.addr == tcpm_pkg::ADDR_CNT_HI_B ? cntHiB_r :
    sfrReq.addr == tcpm_pkg::ADDR_CNT_LO_C ? cntC_r[7:0] :
    sfrReq.addr == tcpm_pkg::ADDR_CNT_HI_C ? cntC_r[15:8] : 8'h00;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeSel_r <= tcpm_pkg::RST_MODE_SEL;
      runFlags_r <= tcpm_pkg::RST_RUN_FLAGS;
      clkDivCfg_r <= tcpm_pkg::RST_CLK_DIV_CFG;
    end else begin
      modeSel_r <= wrMode ? sfrReq.wrData : modeSel_r;
      runFlags_r <= runFlags_nxt;
      clkDivCfg_r <= wrDiv ? sfrReq.wrData : clkDivCfg_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cntLoA_r <= tcpm_pkg::RST_COUNT;
      cntHiA_r <= tcpm_pkg::RST_COUNT;
      cntLoB_r <= tcpm_pkg::RST_COUNT;
      cntHiB_r <= tcpm_pkg::RST_COUNT;
      cntC_r <= '0;
    end else begin
      cntLoA_r <= cntLoA_nxt;
      cntHiA_r <= cntHiA_nxt;
      cntLoB_r <= cntLoB_nxt;
      cntHiB_r <= cntHiB_nxt;
      cntC_r <= cntC_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= 8'h00;
      tOutA_r <= 1'b0;
      tOutB_r <= 1'b0;
    end else begin
      rdData_r <= sfrReq.rd ? rdMux : rdData_r;
      tOutA_r <= ovfA;
      tOutB_r <= ovfB;
    end
  end

  assign sfrRdData = rdData_r;
  assign overflowFlagA = runFlags_r[tcpm_pkg::FLAG_A_BIT];
  assign overflowFlagB = runFlags_r[tcpm_pkg::FLAG_B_BIT];
  assign tOutA = tOutA_r;
  assign tOutB = tOutB_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  modeRstClear_a: assert property (
    !$past(rst_n) |-> modeSel_r == 8'h00)
    else $error("mode register not clear after reset");
  flagOnOvf_a: assert property (
    ovfA |=> overflowFlagA && tOutA)
    else $error("timer 0 overflow did not set flag and output");
  outPulse_a: assert property (
    tOutA |=> !tOutA)
    else $error("timer 0 output longer than one clock");
  runHold_a: assert property (
    !runA && !wrLoA |=> $stable(cntLoA_r))
    else $error("timer 0 counted with run clear");
  gateHoldA_a: assert property (
    halfA.gate && !extHighA && !wrLoA |=> $stable(cntLoA_r))
    else $error("timer 0 counted with gate closed");
  gateHoldB_a: assert property (
    halfB.gate && !extHighB && !wrLoB |=> $stable(cntLoB_r))
    else $error("timer 1 counted with gate closed");
  reloadCopy_a: assert property (
    incA && halfA.mode == tcpm_pkg::MODE_RELOAD && (&cntLoA_r) && !wrLoA
    |=> cntLoA_r == $past(cntHiA_r))
    else $error("reload value not copied");
  wrap13_a: assert property (
    incA && halfA.mode == tcpm_pkg::MODE_13 && (&{cntHiA_r, cntLoA_r[4:0]})
    && !wrLoA && !wrHiA |=> cntHiA_r == 8'h00 && cntLoA_r[4:0] == 5'h00
    && overflowFlagA)
    else $error("13 bit count did not wrap");
  wrap16B_a: assert property (
    incB && halfB.mode == tcpm_pkg::MODE_16 && (&{cntHiB_r, cntLoB_r})
    && !wrLoB && !wrHiB |=> {cntHiB_r, cntLoB_r} == 16'h0000)
    else $error("16 bit count did not wrap");
  fastGap_a: assert property (
    tickFast |=> !tickFast [*3])
    else $error("fast prescale tick too close");
  eventStep_a: assert property (
    halfA.evtSel && enA && evtFallA && halfA.mode == tcpm_pkg::MODE_16
    && !wrLoA && !wrHiA
    |=> {cntHiA_r, cntLoA_r} == $past({cntHiA_r, cntLoA_r}) + 16'h0001)
    else $error("event edge did not step timer 0");
  splitHoldB_a: assert property (
    halfB.mode == tcpm_pkg::MODE_SPLIT && !wrLoB |=> $stable(cntLoB_r))
    else $error("timer 1 counted in mode 3");
  ackClear_a: assert property (
    vectorAckA && !ovfA |=> !overflowFlagA)
    else $error("vector did not clear timer 0 flag");
  readBack_a: assert property (
    sfrReq.rd && sfrReq.addr == tcpm_pkg::ADDR_CNT_LO_A
    |=> sfrRdData == $past(cntLoA_r))
    else $error("low byte read mismatch");

  reloadSeen_c: cover property (
    incA && halfA.mode == tcpm_pkg::MODE_RELOAD && (&cntLoA_r));
  splitFlag_c: cover property (splitA && ovfHiSplit);
  eventCount_c: cover property (halfB.evtSel && incB);

endmodule : tcpm_timer_pair

// ---- src/tcpm_pkg.sv ----
// constants and carrier types for the timer/counter pair block
// assumes an 8-bit special function register bus and one cpu clock
package tcpm_pkg;

  // ----------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_MODE_SEL = 8'h89;
  localparam logic [7:0] ADDR_CNT_LO_A = 8'h8A;
  localparam logic [7:0] ADDR_CNT_LO_B = 8'h8B;
  localparam logic [7:0] ADDR_CNT_HI_A = 8'h8C;
  localparam logic [7:0] ADDR_CNT_HI_B = 8'h8D;
  localparam logic [7:0] ADDR_CLK_DIV_CFG = 8'h8E;
  localparam logic [7:0] ADDR_CNT_LO_C = 8'hCC;
  localparam logic [7:0] ADDR_CNT_HI_C = 8'hCD;
  localparam logic [7:0] RST_MODE_SEL = 8'h00;
  localparam logic [7:0] RST_RUN_FLAGS = 8'h00;
  localparam logic [7:0] RST_CLK_DIV_CFG = 8'h01;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLAG_B_BIT = 7;
  localparam int RUN_B_BIT = 6;
  localparam int FLAG_A_BIT = 5;
  localparam int RUN_A_BIT = 4;
  localparam int PRESCALE_A_BIT = 3;
  localparam int PRESCALE_B_BIT = 4;
  localparam int EVT_A_PORT0_BIT = 5;
  localparam int EVT_B_PORT0_BIT = 6;
  localparam int EVT_C_PORT1_BIT = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DIV_FAST = 4;
  localparam int DIV_SLOW = 12;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_13 = 2'h0,
    MODE_16 = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } tcpm_mode_t;

  // one nibble of the mode register, upper bit first
  typedef struct packed {
    logic gate;
    logic evtSel;
    tcpm_mode_t mode;
  } tcpm_mode_half_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } tcpm_sfr_req_t;

  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } tcpm_step_t;

endpackage : tcpm_pkg

// ---- src/tcpm_sync_edge.sv ----
// two-flop synchroniser with falling edge strobe per bit
// assumes asynchronous pin inputs and the cpu clock
`timescale 1ns/1ps
module tcpm_sync_edge #(
  parameter int W = 5
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] level,
  output logic [W-1:0] fall
);

  // ----------------------------------------------------------------
  // flops
  // ----------------------------------------------------------------
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // pins idle high, so reset to ones to avoid a false edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign fall = prev_r & ~sync_r;

endmodule : tcpm_sync_edge

// ---- src/tcpm_prescale.sv ----
// free-running divider giving cpu clock /fast and /slow enables
// assumes slow is a multiple of fast
`timescale 1ns/1ps
module tcpm_prescale #(
  parameter int SLOW = tcpm_pkg::DIV_SLOW,
  parameter int FAST = tcpm_pkg::DIV_FAST
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic tickFast,
  output logic tickSlow
);

  localparam int CW = $clog2(SLOW);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic wrapNow;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  assign wrapNow = cnt_r == CW'(SLOW - 1);
  assign cnt_nxt = wrapNow ? '0 : cnt_r + 1'b1;
  assign tickSlow = wrapNow;
  assign tickFast = CW'(cnt_r % CW'(FAST)) == CW'(FAST - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : tcpm_prescale

// ---- verif/tcpm_pin_model.sv ----
// pin-side model: event pins and gate pins in front of the timer pair
// assumes the bench calls pulse and sets gateLvl just after a falling edge
`timescale 1ns/1ps
module tcpm_pin_model (
  input wire logic sys_clk,
  output logic [7:0] port0In,
  output logic [3:0] port1In,
  output logic extIrqPinA_n,
  output logic extIrqPinB_n
);
  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  logic [2:0] evtLvl = 3'h7;
  logic [1:0] gateLvl = 2'h3;
  logic [7:0] noise = 8'h00;
  // unused bits follow a counter stepped every cycle, so a wrong tap miscounts
  always @(negedge sys_clk) begin
    noise <= noise + 8'h01;
  end
  assign port0In = {noise[7], evtLvl[1], evtLvl[0], noise[4:0]};
  assign port1In = {noise[3:1], evtLvl[2]};
  assign extIrqPinA_n = gateLvl[0];
  assign extIrqPinB_n = gateLvl[1];
  // ----------------------------------------------------------------
  // one falling edge, held low past the two-flop sync
  // ----------------------------------------------------------------
  task automatic pulse(input int idx);
    @(negedge sys_clk);
    evtLvl[idx] = 1'b0;
    repeat (3) @(negedge sys_clk);
    evtLvl[idx] = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask : pulse
endmodule : tcpm_pin_model

// ---- verif/tcpm_timer_pair_tb_top.sv ----
// self-checking bench for the timer pair: registers, modes, pins
// assumes the pin model drives the port and gate inputs
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module tcpm_timer_pair_tb_top;
  logic sys_clk;
  logic rst_n = 1'b0;
  tcpm_pkg::tcpm_sfr_req_t sfrReq = '0;
  logic [7:0] sfrRdData;
  logic [7:0] port0In;
  logic [3:0] port1In;
  logic extIrqPinA_n;
  logic extIrqPinB_n;
  logic [1:0] vectorAck = 2'h0;
  logic timer2Run = 1'b0;
  logic timer2EventSel = 1'b0;
  logic [1:0] flag;
  logic [1:0] tOut;
  int bad_count = 0;
  int checks = 0;
  int outCnt [2] = '{0, 0};
  logic [7:0] rd;
  tcpm_timer_pair i_tcpm_timer_pair (.sys_clk(sys_clk), .rst_n(rst_n),
    .sfrReq(sfrReq), .sfrRdData(sfrRdData), .port0In(port0In),
    .port1In(port1In), .extIrqPinA_n(extIrqPinA_n),
    .extIrqPinB_n(extIrqPinB_n), .vectorAckA(vectorAck[0]),
    .vectorAckB(vectorAck[1]), .timer2Run(timer2Run),
    .timer2EventSel(timer2EventSel), .overflowFlagA(flag[0]),
    .overflowFlagB(flag[1]), .tOutA(tOut[0]), .tOutB(tOut[1]));
  tcpm_pin_model i_tcpm_pin_model (.sys_clk(sys_clk), .port0In(port0In),
    .port1In(port1In), .extIrqPinA_n(extIrqPinA_n),
    .extIrqPinB_n(extIrqPinB_n));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // sampled mid-cycle, away from the edge that launches the pulse
  always @(negedge sys_clk) begin
    if (tOut[0] === 1'b1) outCnt[0]++;
    if (tOut[1] === 1'b1) outCnt[1]++;
  end
  // ----------------------------------------------------------------
  // expectation of one count step
  // ----------------------------------------------------------------
  function automatic tcpm_pkg::tcpm_step_t f_step(input logic b,
      input tcpm_pkg::tcpm_mode_t m, input logic [7:0] lo,
      input logic [7:0] hi);
    tcpm_pkg::tcpm_step_t s;
    logic [12:0] v;
    s = {1'b0, hi, lo};
    v = {hi, lo[4:0]} + 13'h0001;
    case (m)
      tcpm_pkg::MODE_13: s = {v == 13'h0000, v[12:5], lo[7:5], v[4:0]};
      tcpm_pkg::MODE_16: s = {1'b0, hi, lo} + 17'h00001;
      tcpm_pkg::MODE_RELOAD: s = (lo == 8'hFF) ? {1'b1, hi, hi} :
        {1'b0, hi, lo + 8'h01};
      // timer 1 holds in split mode
      default: if (!b) s = {lo == 8'hFF, hi, lo + 8'h01};
    endcase
    return s;
  endfunction : f_step
  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfrReq.addr = a;
    sfrReq.wrData = d;
    sfrReq.wr = 1'b1;
    @(negedge sys_clk);
    sfrReq.wr = 1'b0;
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    sfrReq.addr = a;
    sfrReq.rd = 1'b1;
    @(negedge sys_clk);
    sfrReq.rd = 1'b0;
    d = sfrRdData;
  endtask : sfr_rd
  function automatic logic [7:0] lo_a(input logic b);
    return b ? tcpm_pkg::ADDR_CNT_LO_B : tcpm_pkg::ADDR_CNT_LO_A;
  endfunction : lo_a
  function automatic logic [7:0] hi_a(input logic b);
    return b ? tcpm_pkg::ADDR_CNT_HI_B : tcpm_pkg::ADDR_CNT_HI_A;
  endfunction : hi_a
  task automatic setup(input logic b, input logic [3:0] nib,
      input logic [7:0] lo, input logic [7:0] hi, input logic run);
    sfr_wr(tcpm_pkg::ADDR_RUN_FLAGS, 8'h00);
    sfr_wr(lo_a(b), lo);
    sfr_wr(hi_a(b), hi);
    sfr_wr(tcpm_pkg::ADDR_MODE_SEL, b ? {nib, 4'h0} : {4'h0, nib});
    sfr_wr(tcpm_pkg::ADDR_RUN_FLAGS, {1'b0, run & b, 1'b0, run & ~b, 4'h0});
  endtask : setup
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic evt_case(input logic b, input tcpm_pkg::tcpm_mode_t m,
      input logic [7:0] lo, input logic [7:0] hi);
    tcpm_pkg::tcpm_step_t e;
    int o;
    e = f_step(b, m, lo, hi);
    setup(b, {2'b01, m}, lo, hi, 1'b1);
    o = outCnt[b];
    i_tcpm_pin_model.pulse(b);
    sfr_rd(lo_a(b), rd);
    `CHK(rd, e.lo)
    sfr_rd(hi_a(b), rd);
    `CHK(rd, e.hi)
    `CHK(flag[b], e.ovf)
    if (m == tcpm_pkg::MODE_13 || m == tcpm_pkg::MODE_16)
      `CHK(outCnt[b] - o, int'(e.ovf))
    vectorAck[b] = 1'b1;
    @(negedge sys_clk);
    vectorAck[b] = 1'b0;
    @(negedge sys_clk);
    `CHK(flag[b], 1'b0)
  endtask : evt_case
  task automatic gate_case(input logic b, input logic g, input logic run,
      input logic pin);
    i_tcpm_pin_model.gateLvl[b] = pin;
    setup(b, {g, 1'b1, tcpm_pkg::MODE_16}, 8'h00, 8'h00, run);
    i_tcpm_pin_model.pulse(b);
    sfr_rd(lo_a(b), rd);
    `CHK(rd, {7'h00, run & (pin | ~g)})
    i_tcpm_pin_model.gateLvl[b] = 1'b1;
  endtask : gate_case
  task automatic pre_case(input logic b, input logic fast);
    int d;
    d = fast ? tcpm_pkg::DIV_FAST : tcpm_pkg::DIV_SLOW;
    sfr_wr(tcpm_pkg::ADDR_CLK_DIV_CFG, {3'h0, fast & b, fast & ~b, 3'h1});
    setup(b, {2'b00, tcpm_pkg::MODE_16}, 8'h00, 8'h00, 1'b1);
    repeat (96) @(negedge sys_clk);
    sfr_wr(tcpm_pkg::ADDR_RUN_FLAGS, 8'h00);
    sfr_rd(lo_a(b), rd);
    `CHK(rd >= 96 / d && rd <= 96 / d + 1, 1'b1)
  endtask : pre_case
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // sized from roughly 1600 cycles of tests, with wide margin
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
  initial begin
    logic [7:0] addrs [9];
    logic [7:0] v;
    addrs = '{8'h88, 8'h89, 8'h8E, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hCC, 8'hCD};
    void'($urandom(32'h7c68));
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      sfr_rd(addrs[i], rd);
      `CHK(rd, i == 2 ? tcpm_pkg::RST_CLK_DIV_CFG : 8'h00)
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      sfr_wr(tcpm_pkg::ADDR_MODE_SEL, v);
      sfr_rd(tcpm_pkg::ADDR_MODE_SEL, rd);
      `CHK(rd, v)
    end
    sfr_wr(8'h8F, 8'h5A);
    sfr_rd(8'h8F, rd);
    `CHK(rd, 8'h00)
    for (int b = 0; b < 2; b++) begin
      for (int m = 0; m < 4; m++) begin
        evt_case(1'(b), tcpm_pkg::tcpm_mode_t'(m), 8'hFF,
          (m == 2) ? 8'h5A : 8'hFF);
      end
      for (int k = 0; k < 8; k++) gate_case(1'(b), k[2], k[1], k[0]);
      pre_case(1'(b), 1'b0);
      pre_case(1'(b), 1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      evt_case(1'($urandom_range(1)),
        tcpm_pkg::tcpm_mode_t'($urandom_range(3)), 8'($urandom),
        8'($urandom));
    end
    sfr_wr(tcpm_pkg::ADDR_CNT_LO_C, 8'hFF);
    sfr_wr(tcpm_pkg::ADDR_CNT_HI_C, 8'h00);
    timer2EventSel = 1'b1;
    timer2Run = 1'b1;
    i_tcpm_pin_model.pulse(2);
    sfr_rd(tcpm_pkg::ADDR_CNT_HI_C, rd);
    `CHK(rd, 8'h01)
    timer2Run = 1'b0;
    i_tcpm_pin_model.pulse(2);
    sfr_rd(tcpm_pkg::ADDR_CNT_LO_C, rd);
    `CHK(rd, 8'h00)
    // 48 cycles hold exactly four slow ticks whatever the divider phase
    timer2EventSel = 1'b0;
    timer2Run = 1'b1;
    repeat (48) @(negedge sys_clk);
    timer2Run = 1'b0;
    sfr_rd(tcpm_pkg::ADDR_CNT_LO_C, rd);
    `CHK(rd, 8'(48 / tcpm_pkg::DIV_SLOW))
    // split high byte runs on timer 1 run bit and sets its flag
    sfr_wr(tcpm_pkg::ADDR_CLK_DIV_CFG, 8'h09);
    setup(1'b0, {2'b00, tcpm_pkg::MODE_SPLIT}, 8'h00, 8'hFF, 1'b0);
    sfr_wr(tcpm_pkg::ADDR_RUN_FLAGS, 8'h40);
    repeat (8) @(negedge sys_clk);
    `CHK(flag, 2'h2)
    conclude();
  end
endmodule : tcpm_timer_pair_tb_top
